//--- src/flash_id_pkg.sv
// Package with constants and types for the flash identification controller.
package flash_id_pkg;

	// ==========================================================
	// Register map of the controller (APB byte addresses).
	localparam logic [7:0] reg_ctrl_addr = 8'h00;
	localparam logic [7:0] reg_addr_addr = 8'h04;
	localparam logic [7:0] reg_stat_addr = 8'h08;
	localparam logic [7:0] reg_data0     = 8'h0c;
	localparam logic [7:0] reg_data1     = 8'h10;

	// ==========================================================
	// Control register fields.
	localparam int ctrl_go_bit   = 0;
	localparam int ctrl_four_bit = 1;
	localparam int ctrl_cmd_lsb  = 8;
	localparam int ctrl_len_lsb  = 16;

	// ==========================================================
	// Operation codes sent on the link.
	localparam logic [7:0] op_mfr_dev  = 8'h90;
	localparam logic [7:0] op_mfr_dual = 8'h92;
	localparam logic [7:0] op_mfr_quad = 8'h94;
	localparam logic [7:0] op_unique   = 8'h4b;
	localparam logic [7:0] op_std_id   = 8'h9f;
	localparam logic [7:0] op_table    = 8'h5a;
	localparam logic [7:0] op_sec_erase = 8'h44;
	localparam logic [7:0] mode_bits   = 8'hf0;

	// ==========================================================
	// Timing: link clock half period is half_period plus one pclk cycles.
	localparam logic [3:0] half_period = 4'h4;
	localparam logic [7:0] quad_dummy_clocks = 8'h04;
	localparam logic [7:0] table_dummy_clocks = 8'h08;

	typedef enum logic [2:0] {
		st_idle  = 3'b000,
		st_low   = 3'b001,
		st_high  = 3'b010,
		st_end   = 3'b011
	} link_state_e;

	// Pin group driven toward the flash.
	typedef struct packed {
		logic       cs_n;
		logic       sclk;
		logic [3:0] io_out;
		logic [3:0] io_oe;
	} pins_s;

endpackage

//--- src/flash_id_host.sv
// Host controller that issues identification and erase commands to a flash.
`timescale 1ns/100ps

// What this block does
// - Send 90h plus 24 zero address bits, then read maker and device bytes.
// - Each ID read ends by raising chip select; data on falling edges.
// - Send 92h, zero address two bits per clock, read ID two bits per clock.
// - Dual ID read sends mode bits with upper nibble all ones.
// - Send 94h, four dummy clocks, zero address by nibbles, quad data.
// - Quad ID read sends mode bits with upper nibble all ones.
// - Four-byte mode makes dual and quad ID address 32 bits.
// - Send 4Bh and four dummy bytes, then read a 64-bit serial number.
// - Four-byte mode needs five dummy bytes for the serial number read.
// - Send 5Ah, 24-bit address, eight dummy clocks, then read table bytes.
// - Table address upper sixteen bits are zero; low byte selects start.
// - Table read always uses a 24-bit address.
// - Erase address selects register one to three in bits 15 to 12.
// - Chip select rises exactly after the last address bit for erase if the length field is zero.
module flash_id_host
	import flash_id_pkg::*;
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	output logic             cs_n,
	output logic             sclk,
	output logic      [3:0]  io_out,
	output logic      [3:0]  io_oe,
	input  wire logic [3:0]  io_in
);

	// ==========================================================
	// Phase widths: lanes used on the link in each stage.
	function automatic logic [2:0] lanes(input logic [7:0] op,
	                                     input logic       stage);
		if (op == op_mfr_dual)
			lanes = 3'd2;
		else if (op == op_mfr_quad)
			lanes = stage ? 3'd4 : 3'd1;
		else
			lanes = 3'd1;
		if (!stage)
			lanes = 3'd1;
	endfunction

	// ==========================================================
	// Synchroniser for returning data.
	logic [3:0] io_meta;
	logic [3:0] io_sync;

	// Registers and sequencer state.
	logic [31:0] addr_reg;
	logic [7:0]  cmd;
	logic        four_byte;
	logic [7:0]  rx_len;
	logic        busy;
	logic [63:0] rx_data;
	link_state_e state;
	logic [3:0]  tick;
	logic [9:0]  bit_cnt;
	logic [71:0] tx_sr;
	logic [9:0]  tx_bits;
	logic [9:0]  rx_start;
	logic [2:0]  mid_lanes;
	logic        quad_dummy;

	logic [31:0] next_addr_reg;
	logic [7:0]  next_cmd;
	logic        next_four_byte;
	logic [7:0]  next_rx_len;
	logic        next_busy;
	logic [63:0] next_rx_data;
	link_state_e next_state;
	logic [3:0]  next_tick;
	logic [9:0]  next_bit_cnt;
	logic [71:0] next_tx_sr;
	logic [9:0]  next_tx_bits;
	logic [9:0]  next_rx_start;
	logic [2:0]  next_mid_lanes;
	logic        next_quad_dummy;
	pins_s       pins;
	pins_s       next_pins;
	logic [31:0] next_prdata;
	logic        next_pready;
	logic        next_pslverr;

	logic        acc;
	logic [2:0]  lw;

	assign acc = psel && penable && !pready;

	always_comb begin
		next_addr_reg   = addr_reg;
		next_cmd        = cmd;
		next_four_byte  = four_byte;
		next_rx_len     = rx_len;
		next_busy       = busy;
		next_rx_data    = rx_data;
		next_state      = state;
		next_tick       = tick;
		next_bit_cnt    = bit_cnt;
		next_tx_sr      = tx_sr;
		next_tx_bits    = tx_bits;
		next_rx_start   = rx_start;
		next_mid_lanes  = mid_lanes;
		next_quad_dummy = quad_dummy;
		next_pins       = pins;
		next_prdata     = prdata;
		next_pready     = acc;
		next_pslverr    = 1'b0;
		lw              = 3'd1;

		// APB slave: one wait cycle, answer in the access phase.
		if (acc) begin
			next_prdata = 32'h0000_0000;
			case (paddr)
				reg_ctrl_addr: begin
					if (pwrite && !busy) begin
						next_cmd       = pwdata[ctrl_cmd_lsb +: 8];
						next_four_byte = pwdata[ctrl_four_bit];
						next_rx_len    = pwdata[ctrl_len_lsb +: 8];
					end
					if (pwrite && !busy && pwdata[ctrl_go_bit])
						next_busy = 1'b1;
					next_prdata = {8'h00, rx_len, cmd, 6'h00,
					               four_byte, busy};
				end
				reg_addr_addr: begin
					if (pwrite && !busy)
						next_addr_reg = pwdata;
					next_prdata = addr_reg;
				end
				reg_stat_addr: next_prdata = {31'h0, busy};
				reg_data0:     next_prdata = rx_data[31:0];
				reg_data1:     next_prdata = rx_data[63:32];
				default:       next_pslverr = 1'b1;
			endcase
		end

		case (state)
			st_idle: begin
				next_pins.cs_n  = 1'b1;
				next_pins.sclk  = 1'b0;
				next_pins.io_oe = 4'h0;
				if (busy) begin
					// Build the outgoing bit stream, MSB first.
					next_tx_sr      = '0;
					next_quad_dummy = 1'b0;
					next_mid_lanes  = 3'd1;
					next_rx_data    = '0;
					case (cmd)
						op_mfr_dev: begin
							next_tx_sr[71 -: 32] = {op_mfr_dev, 24'h0};
							next_tx_bits = 10'd32;
						end
						op_mfr_dual, op_mfr_quad: begin
							next_mid_lanes = lanes(cmd, 1'b1);
							next_quad_dummy = (cmd == op_mfr_quad);
							// Zero address then Fx mode bits.
							next_tx_sr[71 -: 48] = four_byte ?
							    {cmd, 32'h0, mode_bits} :
							    {cmd, 24'h0, mode_bits, 8'h0};
							next_tx_bits = four_byte ? 10'd48 : 10'd40;
						end
						op_unique: begin
							next_tx_sr[71 -: 8] = op_unique;
							// Dummy bytes.
							next_tx_bits = four_byte ? 10'd48 : 10'd40;
						end
						op_table: begin
							// Upper address zero, always 24 bits.
							next_tx_sr[71 -: 32] = {op_table, 16'h0,
							                        addr_reg[7:0]};
							next_tx_bits = 10'd32 + 10'(table_dummy_clocks);
						end
						op_sec_erase: begin
							// Register select in bits 15:12.
							next_tx_sr[71 -: 40] = {op_sec_erase, 16'h0,
							    addr_reg[15:12], 4'h0, 8'h0};
							next_tx_bits = four_byte ? 10'd40 : 10'd32;
							if (!four_byte)
								next_tx_sr[71 -: 32] = {op_sec_erase, 8'h0,
								    addr_reg[15:12], 4'h0, 8'h0};
						end
						default: begin
							next_tx_sr[71 -: 8] = cmd;
							next_tx_bits = 10'd8;
						end
					endcase
					// Erase with rx_len zero reads nothing, so chip select rises right
					// after the last address bit.
					next_rx_start = next_tx_bits;
					if (next_quad_dummy)
						next_rx_start = 10'd8 + 10'(quad_dummy_clocks) +
						    ((next_tx_bits - 10'd8) >> 2);
					else if (next_mid_lanes == 3'd2)
						next_rx_start = 10'd8 + ((next_tx_bits - 10'd8) >> 1);
					next_bit_cnt = '0;
					next_tick    = '0;
					next_pins.cs_n = 1'b0;
					next_state   = st_low;
				end
			end
			st_low: begin
				// Drive data while the link clock is low.
				lw = (bit_cnt < 10'd8) ? 3'd1 : mid_lanes;
				if (quad_dummy && bit_cnt >= 10'd8 &&
				    bit_cnt < 10'd8 + 10'(quad_dummy_clocks))
					lw = 3'd4;
				next_pins.io_oe = (bit_cnt < rx_start) ?
				    ((lw == 3'd4) ? 4'hf : (lw == 3'd2) ? 4'h3 : 4'h1) :
				    4'h0;
				if (lw == 3'd4)
					next_pins.io_out = tx_sr[71:68];
				else if (lw == 3'd2)
					next_pins.io_out = {2'b00, tx_sr[71:70]};
				else
					next_pins.io_out = {3'b000, tx_sr[71]};
				next_tick = tick + 4'd1;
				if (tick == half_period) begin
					next_tick = '0;
					next_pins.sclk = 1'b1;
					next_state = st_high;
				end
			end
			st_high: begin
				lw = (bit_cnt < 10'd8) ? 3'd1 : mid_lanes;
				next_tick = tick + 4'd1;
				if (tick == half_period) begin
					next_tick = '0;
					next_pins.sclk = 1'b0;
					if (!(quad_dummy && bit_cnt >= 10'd8 &&
					      bit_cnt < 10'd8 + 10'(quad_dummy_clocks)))
						next_tx_sr = tx_sr << lw;
					// Sample data the device shifted on the falling edge.
					if (bit_cnt >= rx_start) begin
						if (mid_lanes == 3'd4)
							next_rx_data = {rx_data[59:0], io_sync};
						else if (mid_lanes == 3'd2)
							next_rx_data = {rx_data[61:0], io_sync[1:0]};
						else
							next_rx_data = {rx_data[62:0], io_sync[1]};
					end
					next_bit_cnt = bit_cnt + 10'd1;
					if (bit_cnt + 10'd1 >= rx_start +
					    {2'b00, rx_len} * 10'(mid_lanes == 3'd1 ? 8 :
					     mid_lanes == 3'd2 ? 4 : 2))
						next_state = st_end;
					else
						next_state = st_low;
				end
			end
			st_end: begin
				next_pins.cs_n  = 1'b1;
				next_pins.io_oe = 4'h0;
				next_busy  = 1'b0;
				next_state = st_idle;
			end
			default: next_state = st_idle;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			io_meta    <= '0;
			io_sync    <= '0;
			addr_reg   <= '0;
			cmd        <= op_std_id;
			four_byte  <= 1'b0;
			rx_len     <= 8'h03;
			busy       <= 1'b0;
			rx_data    <= '0;
			state      <= st_idle;
			tick       <= '0;
			bit_cnt    <= '0;
			tx_sr      <= '0;
			tx_bits    <= '0;
			rx_start   <= '0;
			mid_lanes  <= 3'd1;
			quad_dummy <= 1'b0;
			pins       <= '{cs_n: 1'b1, sclk: 1'b0, io_out: 4'h0,
			                io_oe: 4'h0};
			prdata     <= '0;
			pready     <= 1'b0;
			pslverr    <= 1'b0;
		end else begin
			io_meta    <= io_in;
			io_sync    <= io_meta;
			addr_reg   <= next_addr_reg;
			cmd        <= next_cmd;
			four_byte  <= next_four_byte;
			rx_len     <= next_rx_len;
			busy       <= next_busy;
			rx_data    <= next_rx_data;
			state      <= next_state;
			tick       <= next_tick;
			bit_cnt    <= next_bit_cnt;
			tx_sr      <= next_tx_sr;
			tx_bits    <= next_tx_bits;
			rx_start   <= next_rx_start;
			mid_lanes  <= next_mid_lanes;
			quad_dummy <= next_quad_dummy;
			pins       <= next_pins;
			prdata     <= next_prdata;
			pready     <= next_pready;
			pslverr    <= next_pslverr;
		end
	end

	assign cs_n   = pins.cs_n;
	assign sclk   = pins.sclk;
	assign io_out = pins.io_out;
	assign io_oe  = pins.io_oe;

endmodule

//--- sim/flash_id_checker.sv
// Checker for bus and link timing of the flash identification host.
`timescale 1ns/100ps
module flash_id_checker
	import flash_id_pkg::*;
(
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        cs_n,
	input wire logic        sclk,
	input wire logic [3:0]  io_out,
	input wire logic [3:0]  io_oe
);
	// ==========================================================
	// Bus and link properties.
	default clocking dc @(posedge pclk); endclocking
	default disable iff (!presetn);
	bus_wait_a: assert property (psel && penable && !pready |=> pready)
		else $error("pready late");
	pready_pulse_a: assert property (pready |=> !pready)
		else $error("pready held");
	err_pair_a: assert property (pslverr |-> pready)
		else $error("pslverr alone");
	frame_start_a: assert property (psel && pready && pwrite &&
		paddr == reg_ctrl_addr && pwdata[0] && cs_n |-> ##[1:2] !cs_n)
		else $error("frame did not start");
	clk_high_a: assert property ($rose(sclk) |-> sclk[*5] ##1 !sclk)
		else $error("link clock high phase wrong");
	data_hold_a: assert property (sclk && $past(sclk) |-> $stable(io_out))
		else $error("data moved while clock high");
	idle_pins_a: assert property (cs_n |-> !sclk && io_oe == 4'h0)
		else $error("link active while deselected");
	end_low_a: assert property ($rose(cs_n) |-> !$past(sclk))
		else $error("deselect with clock high");
endmodule

bind flash_id_host flash_id_checker chk (.pclk, .presetn, .psel, .penable,
	.pwrite, .paddr, .pwdata, .pready, .pslverr, .cs_n, .sclk, .io_out, .io_oe);

//--- sim/flash_dev_model.sv
// Behavioural flash device answering identification and erase frames.
`timescale 1ns/100ps
module flash_dev_model
	import flash_id_pkg::*;
#(
	parameter logic [7:0]  mfr  = 8'h3c, // Arbitrary value.
	parameter logic [7:0]  dev  = 8'h21, // Arbitrary value.
	parameter logic [15:0] jid  = 16'h6a1b, // Arbitrary value.
	parameter logic [63:0] uid  = 64'h0123456789abcdef, // Arbitrary value.
	parameter logic [3:1]  secreg_otp_lock_bits = 3'b100
)
(
	input  wire logic        cs_n,
	input  wire logic        sclk,
	input  wire logic [3:0]  io,
	input  wire logic        four,
	output logic      [3:0]  drv,
	output logic      [3:0]  drv_en,
	output logic      [3:1]  erased,
	output logic      [31:0] rx_lo
);
	int          n;
	int          w;
	logic [7:0]  op;
	logic [63:0] rx;
	logic [63:0] tx;
	logic        write_enable_latch;
	logic        busy;
	logic [1:0]  sel;
	// ==========================================================
	// Input clocks before the first output bit.
	function automatic int need(input logic [7:0] o);
		case (o)
			op_mfr_dev: return 32;
			op_mfr_dual: return four ? 28 : 24;
			op_mfr_quad: return four ? 22 : 20;
			op_unique: return four ? 48 : 40;
			op_table: return 40;
			op_sec_erase, 8'h06: return 999;
			default: return 8;
		endcase
	endfunction
	initial begin
		n = 0;
		op = 8'h00;
		write_enable_latch = 1'b0;
		busy = 1'b0;
		erased = 3'b000;
		drv = 4'h0;
		drv_en = 4'h0;
	end
	assign rx_lo = rx[31:0];
	always @(negedge cs_n) begin
		n = 0;
		rx = 64'h0;
	end
	always @(posedge sclk) begin
		w = (op == op_mfr_dual) ? 2 : (op == op_mfr_quad) ? 4 : 1;
		if (n < 8) op = {op[6:0], io[0]};
		else if (n < need(op)) rx = (rx << w) | 64'(io & 4'((1 << w) - 1));
		n = n + 1;
		if (n == need(op)) begin
			case (op)
				op_unique: tx = uid;
				op_std_id: tx = {mfr, jid, 40'h0};
				8'h05: tx = {6'h00, write_enable_latch, busy, 56'h0};
				op_table: for (int i = 0; i < 8; i++)
					tx[63 - 8 * i -: 8] = ~(rx[15:8] + 8'(i));
				default: tx = {4{mfr, dev}};
			endcase
		end
	end
	always @(negedge sclk) begin
		if (!cs_n && n >= need(op)) begin
			drv_en = (w == 1) ? 4'h2 : (w == 2) ? 4'h3 : 4'hf;
			drv = (w == 1) ? {2'b00, tx[63], 1'b0} :
				(w == 2) ? {2'b00, tx[63:62]} : tx[63:60];
			tx = tx << w;
		end
	end
	always @(posedge cs_n) begin
		drv_en = 4'h0;
		if (op == 8'h06 && n == 8) write_enable_latch = 1'b1;
		if (op == op_sec_erase && write_enable_latch && !busy &&
			n == (four ? 40 : 32) && rx[31:14] == 0 &&
			rx[11:8] == 0 && rx[13:12] != 0 &&
			!secreg_otp_lock_bits[rx[13:12]]) begin
			sel = rx[13:12];
			busy = 1'b1;
		end
	end
	always @(posedge busy) begin
		#20000;
		erased[sel] = 1'b1;
		write_enable_latch = 1'b0;
		busy = 1'b0;
	end
endmodule

//--- sim/test_flash_id_and_secreg_commands.sv
// Self-checking bench for the flash identification host controller.
`timescale 1ns/100ps
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin errors++; \
	$display("MISMATCH %s expected %h seen %h", nm, e, g); end end
module test_flash_id_and_secreg_commands
	import flash_id_pkg::*;
;
	localparam logic [7:0]  mfr = 8'h3c; // Arbitrary value.
	localparam logic [7:0]  dev = 8'h21; // Arbitrary value.
	localparam logic [15:0] jid = 16'h6a1b; // Arbitrary value.
	localparam logic [63:0] uid = 64'h0123456789abcdef; // Arbitrary value.
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic        cs_n, sclk, four, pat, err;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rd, d0, d1, rx_lo;
	logic [3:0]  io_out, io_oe, io_in, drv, drv_en;
	logic [3:1]  erased;
	int          errors, cmp_count;
	// ==========================================================
	// Wire resolution, clock and instances.
	always_comb for (int i = 0; i < 4; i++)
		io_in[i] = io_oe[i] ? io_out[i] : drv_en[i] ? drv[i] : pat;
	initial begin
		pclk = 1'b0;
		forever #25 pclk = ~pclk;
	end
	always @(posedge pclk) pat <= ~pat;
	flash_id_host uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .cs_n, .sclk, .io_out, .io_oe,
		.io_in);
	flash_dev_model #(.mfr(mfr), .dev(dev), .jid(jid), .uid(uid),
		.secreg_otp_lock_bits(3'b100)) dev_m (.cs_n, .sclk, .io(io_in),
		.four, .drv, .drv_en, .erased, .rx_lo);
	// ==========================================================
	// Tasks.
	task automatic print_verdict();
		$display("compares %0d errors %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] dt);
		int k;
		k = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= dt;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 40);
		if (k >= 40) begin
			errors++;
			print_verdict();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic run(input logic [7:0] op, input logic [7:0] len,
		input logic f, input logic [31:0] a);
		int k;
		k = 0;
		four <= f;
		apb(1'b1, reg_addr_addr, a);
		apb(1'b1, reg_ctrl_addr, {8'h00, len, op, 6'h00, f, 1'b1});
		do begin
			apb(1'b0, reg_stat_addr, 32'h0);
			k++;
		end while (rd[0] !== 1'b0 && k < 400);
		if (k >= 400) begin
			errors++;
			print_verdict();
		end
		apb(1'b0, reg_data0, 32'h0);
		d0 = rd;
		apb(1'b0, reg_data1, 32'h0);
		d1 = rd;
	endtask
	// ==========================================================
	// Scenarios.
	initial begin
		pat = 1'b0;
		four = 1'b0;
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, reg_ctrl_addr, 32'h0);
		`CHK("ctrl reset", 32'h00039f00, rd)
		apb(1'b0, 8'h20, 32'h0);
		`CHK("unmapped", 1'b1, err)
		run(op_std_id, 8'h03, 1'b0, 32'h0);
		`CHK("std id", {mfr, jid}, d0[23:0])
		for (int f = 0; f < 2; f++) begin
			run(op_mfr_dev, 8'h02, f[0], 32'h0);
			`CHK("mfr dev", {mfr, dev}, d0[15:0])
			run(op_mfr_dual, 8'h04, f[0], 32'h00ab1200);
			`CHK("dual id", {2{mfr, dev}}, d0)
			`CHK("dual addr", 24'h0, rx_lo[31:8])
			`CHK("dual mode", 4'hf, rx_lo[7:4])
			run(op_mfr_quad, 8'h04, f[0], 32'h0);
			`CHK("quad id", {2{mfr, dev}}, d0)
			`CHK("quad mode", 4'hf, rx_lo[7:4])
			run(op_unique, 8'h08, f[0], 32'h0);
			`CHK("unique", uid, {d1, d0})
			run(op_table, 8'h04, f[0], 32'h00ab12fe);
			`CHK("table", 32'h0100fffe, d0)
			`CHK("table addr", 24'h0000fe, rx_lo[31:8])
		end
		run(op_sec_erase, 8'h00, 1'b0, 32'h00001000);
		`CHK("erase no wel", 3'b000, erased)
		run(8'h06, 8'h00, 1'b0, 32'h0);
		run(op_sec_erase, 8'h00, 1'b1, 32'h00002000);
		run(8'h05, 8'h01, 1'b0, 32'h0);
		`CHK("busy", 2'b11, d0[1:0])
		repeat (20) if (d0[0] !== 1'b0) run(8'h05, 8'h01, 1'b0, 32'h0);
		`CHK("done", 2'b00, d0[1:0])
		`CHK("erased", 3'b010, erased)
		run(8'h06, 8'h00, 1'b0, 32'h0);
		run(op_sec_erase, 8'h00, 1'b0, 32'h00003000);
		run(8'h05, 8'h01, 1'b0, 32'h0);
		`CHK("locked", 2'b10, d0[1:0])
		`CHK("lock kept", 3'b010, erased)
		print_verdict();
	end
endmodule
